// ==== pkg/usb_ctrl_params.svh ====
// register offsets, field positions and reset values of the usb control block
`ifndef USB_CTRL_PARAMS_SVH
`define USB_CTRL_PARAMS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_GENERAL_CONTROL 12'h000
`define OFS_EP_FLAGS 12'h004
`define OFS_EP_ENABLES 12'h008
`define OFS_HOST_FLAGS 12'h00C
`define OFS_HOST_ENABLES 12'h010
`define OFS_STATUS 12'h014

// ----------------------------------------
// general control fields
// ----------------------------------------
`define CTL_GLOBAL_ENABLE 7
`define CTL_HOST_ROLE 6
`define CTL_CLOCK_FREEZE 5
`define CTL_VBUS_PAD 4
`define CTL_ID_IRQ_EN 1
`define CTL_VBUS_IRQ_EN 0
`define CTL_WRITE_MASK 8'hF3
`define CTL_RESET 8'h20

// ----------------------------------------
// endpoint flag fields
// ----------------------------------------
`define EPF_NAK_OUT 4
`define EPF_SETUP_RX 3
`define EPF_OUT_RX 2
`define EPF_STALL_SENT 1
`define EPF_TX_READY 0
`define EPF_MASK 8'h1F

// ----------------------------------------
// endpoint enable fields
// ----------------------------------------
`define EPE_FLOW_ERR 7
`define EPE_NAK_IN 6
`define EPE_MASK 8'hDF

// ----------------------------------------
// host flag and enable fields
// ----------------------------------------
`define HF_WAKEUP 6
`define HF_SOF 5
`define HF_MASK 8'h7F
`define REG_RESET 8'h00

`endif

// ==== pkg/usb_ctrl_pkg.sv ====
// types shared by the usb control block
package usb_ctrl_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {BUS_IDLE, BUS_ACCESS} bus_state_t;
endpackage : usb_ctrl_pkg

// ==== rtl/sync_in.sv ====
// three-stage synchroniser for asynchronous input levels
`timescale 1ns/1ps
module sync_in #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t st_reg;
  sync_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // a change counts once the second and third stages agree
    for (int i = 0; i < WIDTH; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.stable[i] = st_reg.s3[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.stable;
endmodule : sync_in

// ==== rtl/event_flags.sv ====
// bank of sticky event flags: hardware sets, software clears by writing zero
`timescale 1ns/1ps
module event_flags #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] setPulse,
  input wire logic [WIDTH-1:0] validMask,
  input wire logic clearWrite,
  input wire logic [WIDTH-1:0] clearData,
  input wire logic [WIDTH-1:0] enables,
  output logic [WIDTH-1:0] flags,
  output logic irqAny
);
  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } flag_state_t;

  flag_state_t st_reg;
  flag_state_t st_next;

  always_comb begin
    st_next = st_reg;
    // writing one is ignored, writing zero clears
    if (clearWrite) begin
      st_next.flags = st_reg.flags & clearData;
    end
    // a set in the same cycle as a clear wins
    st_next.flags = (st_next.flags | setPulse) & validMask;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign flags = st_reg.flags;
  assign irqAny = |(st_reg.flags & enables);
endmodule : event_flags

// ==== rtl/usb_ctrl_irq_flags.sv ====
// control register, event flags and interrupt outputs of the usb controller
`timescale 1ns/1ps
`include "usb_ctrl_params.svh"
module usb_ctrl_irq_flags (
  input wire logic core_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // endpoint engine events, one-cycle pulses on core_clk; endpointIsIn and the last three flags are levels
  input wire logic endpointIsIn,
  input wire logic nakOutSent,
  input wire logic setupReceived,
  input wire logic outReceived,
  input wire logic stallSent,
  input wire logic isoCrcError,
  input wire logic bankFree,
  input wire logic bankKillDone,
  input wire logic overflowFlag,
  input wire logic underflowFlag,
  input wire logic nakInFlag,
  // host engine events, one-cycle pulses on core_clk
  input wire logic sofIssued,
  input wire logic keepAliveSent,
  input wire logic upstreamResume,
  input wire logic resumeSent,
  input wire logic busResetSent,
  input wire logic deviceAttached,
  input wire logic deviceDetached,
  // asynchronous pin levels
  input wire logic busNonIdle,
  input wire logic idPin,
  input wire logic vbusPin,
  // controls to the usb macro
  output logic controllerReset,
  output logic transceiverEnable,
  output logic usbClockEnable,
  output logic resumeDetectEnable,
  output logic hostMode,
  output logic vbusPadEnable,
  output logic bankKillRequest,
  // interrupt requests
  output logic endpointIrq,
  output logic hostIrq,
  output logic generalIrq
);
  import usb_ctrl_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    byte_t ctrl;
    byte_t epEnables;
    byte_t hostEnables;
    logic bankKill;
    logic idLast;
    logic vbusLast;
    logic idChange;
    logic vbusChange;
    logic wakeLast;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } ctrl_state_t;

  ctrl_state_t st_reg;
  ctrl_state_t st_next;

  logic [2:0] pinSync;
  byte_t epFlags;
  byte_t hostFlags;
  byte_t epSet;
  byte_t hostSet;
  byte_t epValid;
  logic epFlagIrq;
  logic hostFlagIrq;
  logic accessPhase;
  logic wrEp;
  logic wrHost;
  logic usbOn;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction : hit

  // byte lane 0 carries every 8-bit register
  function automatic byte_t merge(input byte_t old, input logic [31:0] wd,
                                  input logic [3:0] strb, input byte_t mask);
    byte_t v;
    v = strb[0] ? wd[7:0] : old;
    return v & mask;
  endfunction : merge

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  sync_in #(
    .WIDTH(3)
  ) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in({busNonIdle, idPin, vbusPin}),
    .sync_out(pinSync)
  );

  assign usbOn = st_reg.ctrl[`CTL_GLOBAL_ENABLE];
  assign accessPhase = psel && penable && !st_reg.ready;
  assign wrEp = accessPhase && pwrite && hit(paddr, `OFS_EP_FLAGS) && pstrb[0];
  assign wrHost = accessPhase && pwrite && hit(paddr, `OFS_HOST_FLAGS)
                  && pstrb[0];

  // ----------------------------------------
  // endpoint flags
  // ----------------------------------------
  always_comb begin
    epSet = '0;
    epSet[`EPF_NAK_OUT] = nakOutSent;
    epSet[`EPF_SETUP_RX] = setupReceived;
    epSet[`EPF_OUT_RX] = outReceived && !endpointIsIn;
    epSet[`EPF_STALL_SENT] = stallSent || isoCrcError;
    epSet[`EPF_TX_READY] = bankFree;
    epSet = usbOn ? epSet : '0;
    epValid = `EPF_MASK;
    // direction-dependent flags are held clear
    if (endpointIsIn) begin
      epValid[`EPF_SETUP_RX] = 1'b0;
      epValid[`EPF_OUT_RX] = 1'b0;
    end else begin
      epValid[`EPF_TX_READY] = 1'b0;
    end
    if (!usbOn) begin
      epValid = '0;
    end
  end

  event_flags #(
    .WIDTH(8)
  ) u_ep_flags (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .setPulse(epSet),
    .validMask(epValid),
    .clearWrite(wrEp),
    .clearData(pwdata[7:0]),
    .enables(st_reg.epEnables),
    .flags(epFlags),
    .irqAny(epFlagIrq)
  );

  // ----------------------------------------
  // host flags
  // ----------------------------------------
  always_comb begin
    hostSet = '0;
    hostSet[`HF_WAKEUP] = pinSync[2] && !st_reg.wakeLast;
    hostSet[`HF_SOF] = sofIssued || keepAliveSent;
    hostSet[4] = upstreamResume;
    hostSet[3] = resumeSent;
    hostSet[2] = busResetSent;
    hostSet[1] = deviceDetached;
    hostSet[0] = deviceAttached;
    // host flags only run in host role with the macro on
    hostSet = (usbOn && st_reg.ctrl[`CTL_HOST_ROLE]) ? hostSet : '0;
  end

  event_flags #(
    .WIDTH(8)
  ) u_host_flags (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .setPulse(hostSet),
    .validMask(usbOn ? `HF_MASK : `REG_RESET),
    .clearWrite(wrHost),
    .clearData(pwdata[7:0]),
    .enables(st_reg.hostEnables),
    .flags(hostFlags),
    .irqAny(hostFlagIrq)
  );

  // ----------------------------------------
  // registers and apb
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.ready = 1'b0;
    st_next.err = 1'b0;
    st_next.idLast = pinSync[1];
    st_next.vbusLast = pinSync[0];
    st_next.wakeLast = pinSync[2];
    // transition events, sticky until written as zero in the status register
    if (st_reg.ctrl[`CTL_ID_IRQ_EN] && pinSync[1] != st_reg.idLast) begin
      st_next.idChange = 1'b1;
    end
    if (st_reg.ctrl[`CTL_VBUS_IRQ_EN] && pinSync[0] != st_reg.vbusLast) begin
      st_next.vbusChange = 1'b1;
    end
    if (bankKillDone || !usbOn) begin
      st_next.bankKill = 1'b0;
    end
    if (accessPhase) begin
      st_next.ready = 1'b1;
      st_next.rdata = '0;
      unique case (paddr)
        `OFS_GENERAL_CONTROL: begin
          // vbus pad stays writable even with the macro disabled
          if (pwrite) begin
            st_next.ctrl = merge(st_reg.ctrl, pwdata, pstrb,
                                 `CTL_WRITE_MASK);
          end
          st_next.rdata[7:0] = st_reg.ctrl;
        end
        `OFS_EP_FLAGS: begin
          // kill request: writing one sets it, writing zero is ignored
          if (pwrite && pstrb[0] && endpointIsIn && usbOn
              && pwdata[`EPF_OUT_RX]) begin
            st_next.bankKill = 1'b1;
          end
          st_next.rdata[7:0] = epFlags;
          if (endpointIsIn) begin
            st_next.rdata[`EPF_OUT_RX] = st_reg.bankKill;
          end
        end
        `OFS_EP_ENABLES: begin
          if (pwrite) begin
            st_next.epEnables = merge(st_reg.epEnables, pwdata, pstrb,
                                      `EPE_MASK);
          end
          st_next.rdata[7:0] = st_reg.epEnables;
        end
        `OFS_HOST_FLAGS: begin
          st_next.rdata[7:0] = hostFlags;
        end
        `OFS_HOST_ENABLES: begin
          if (pwrite) begin
            st_next.hostEnables = merge(st_reg.hostEnables, pwdata, pstrb,
                                        `HF_MASK);
          end
          st_next.rdata[7:0] = st_reg.hostEnables;
        end
        `OFS_STATUS: begin
          if (pwrite && pstrb[0]) begin
            st_next.idChange = st_next.idChange & pwdata[1];
            st_next.vbusChange = st_next.vbusChange & pwdata[0];
            // an edge in the clearing cycle still wins
            if (st_reg.ctrl[`CTL_ID_IRQ_EN]
                && pinSync[1] != st_reg.idLast) begin
              st_next.idChange = 1'b1;
            end
            if (st_reg.ctrl[`CTL_VBUS_IRQ_EN]
                && pinSync[0] != st_reg.vbusLast) begin
              st_next.vbusChange = 1'b1;
            end
          end
          st_next.rdata[4] = pinSync[1];
          st_next.rdata[3] = pinSync[0];
          st_next.rdata[1] = st_reg.idChange;
          st_next.rdata[0] = st_reg.vbusChange;
        end
        default: begin
          st_next.err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.ctrl <= `CTL_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = st_reg.rdata;
  assign pready = st_reg.ready;
  assign pslverr = st_reg.err;
  assign controllerReset = !usbOn;
  assign transceiverEnable = usbOn;
  assign usbClockEnable = usbOn && !st_reg.ctrl[`CTL_CLOCK_FREEZE];
  assign resumeDetectEnable = usbOn;
  assign hostMode = st_reg.ctrl[`CTL_HOST_ROLE];
  assign vbusPadEnable = st_reg.ctrl[`CTL_VBUS_PAD];
  assign bankKillRequest = st_reg.bankKill;
  assign endpointIrq = epFlagIrq
    || (st_reg.epEnables[`EPE_FLOW_ERR] && (overflowFlag || underflowFlag))
    || (st_reg.epEnables[`EPE_NAK_IN] && nakInFlag);
  assign hostIrq = hostFlagIrq;
  // a sticky change raises the request only while its enable is set
  assign generalIrq = (st_reg.idChange && st_reg.ctrl[`CTL_ID_IRQ_EN])
    || (st_reg.vbusChange && st_reg.ctrl[`CTL_VBUS_IRQ_EN]);
endmodule : usb_ctrl_irq_flags

// ==== dv/usb_ctrl_irq_flags_checker.sv ====
// concurrent checks on the ports of the usb control block
`timescale 1ns/1ps
`include "usb_ctrl_params.svh"
module usb_ctrl_irq_flags_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic endpointIsIn,
  input wire logic bankKillDone,
  input wire logic controllerReset,
  input wire logic transceiverEnable,
  input wire logic usbClockEnable,
  input wire logic resumeDetectEnable,
  input wire logic hostMode,
  input wire logic vbusPadEnable,
  input wire logic bankKillRequest,
  input wire logic hostIrq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // write cycles taken by the slave
  // ----------------------------------------
  sequence killWrite;
    psel && penable && !pready && pwrite && paddr == `OFS_EP_FLAGS &&
      pwdata[2] && endpointIsIn && transceiverEnable;
  endsequence
  sequence padWrite;
    psel && penable && !pready && pwrite &&
      paddr == `OFS_GENERAL_CONTROL && pwdata[4];
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  AST_RESET_FOLLOWS_ENABLE: assert property (controllerReset == !transceiverEnable)
    else $error("controller reset not the inverse of enable");
  AST_FLAGS_HELD_OFF: assert property ($past(!transceiverEnable) && !transceiverEnable |-> !hostIrq)
    else $error("host irq while controller disabled");
  AST_CLOCK_NEEDS_ENABLE: assert property (usbClockEnable |-> transceiverEnable)
    else $error("usb clock runs while disabled");
  AST_RESUME_DETECT: assert property (resumeDetectEnable == transceiverEnable)
    else $error("resume detection does not follow enable");
  AST_RESERVED_ZERO: assert property (pready && !pwrite && paddr == `OFS_GENERAL_CONTROL |-> prdata[3:2] == 2'h0 && prdata[31:8] == 24'h0)
    else $error("reserved control bits read nonzero");
  AST_ROLE_BY_WRITE: assert property (!$stable(hostMode) |-> $past(psel && penable && pwrite && paddr == `OFS_GENERAL_CONTROL))
    else $error("role changed without control write");
  AST_PAD_WRITABLE: assert property (padWrite |=> vbusPadEnable)
    else $error("vbus pad enable not written");
  AST_KILL_SET: assert property (killWrite |=> bankKillRequest)
    else $error("bank kill request not set");
  AST_KILL_DONE: assert property (bankKillDone && !(psel && penable && pwrite) |=> !bankKillRequest)
    else $error("bank kill not cleared when done");
endmodule : usb_ctrl_irq_flags_checker

bind usb_ctrl_irq_flags usb_ctrl_irq_flags_checker chk (
  .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .endpointIsIn(endpointIsIn), .bankKillDone(bankKillDone),
  .controllerReset(controllerReset), .transceiverEnable(transceiverEnable),
  .usbClockEnable(usbClockEnable), .resumeDetectEnable(resumeDetectEnable),
  .hostMode(hostMode), .vbusPadEnable(vbusPadEnable),
  .bankKillRequest(bankKillRequest), .hostIrq(hostIrq)
);

// ==== dv/usb_bus_model.sv ====
// usb bus engine model: event pulses on command, one cycle after fire and for as long as fire is held
`timescale 1ns/1ps
module usb_bus_model (
  input wire logic core_clk,
  input wire logic fire,
  input wire logic [3:0] evIdx,
  output logic [15:0] pulses
);
  // each event pulses for as many cycles as fire is held high
  always_ff @(posedge core_clk) begin
    pulses <= fire ? (16'h0001 << evIdx) : 16'h0000;
  end
endmodule : usb_bus_model

// ==== dv/test_usb_ctrl_irq_flags.sv ====
// register and event tests of the usb control block
`timescale 1ns/1ps
`include "usb_ctrl_params.svh"
module test_usb_ctrl_irq_flags;
  import usb_ctrl_pkg::*;
  logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, endpointIsIn = 0, fire = 0;
  logic overflowFlag = 0, underflowFlag = 0, nakInFlag = 0;
  logic busNonIdle = 0, idPin = 0, vbusPin = 0;
  logic [3:0] evIdx = 4'h0;
  logic [15:0] p;
  logic controllerReset, transceiverEnable, usbClockEnable, hostMode;
  logic vbusPadEnable, bankKillRequest, endpointIrq, hostIrq, generalIrq;
  int bad_count = 0, comparisons = 0;
  logic [8:0] e;
  logic [11:0] a;
  usb_bus_model bus (.core_clk(core_clk), .fire(fire), .evIdx(evIdx),
    .pulses(p));
  usb_ctrl_irq_flags uut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .endpointIsIn(endpointIsIn), .nakOutSent(p[0]), .setupReceived(p[1]),
    .outReceived(p[2]), .stallSent(p[3]), .isoCrcError(p[4]),
    .bankFree(p[5]), .bankKillDone(p[6]), .overflowFlag(overflowFlag),
    .underflowFlag(underflowFlag), .nakInFlag(nakInFlag), .sofIssued(p[7]),
    .keepAliveSent(p[8]), .upstreamResume(p[9]), .resumeSent(p[10]),
    .busResetSent(p[11]), .deviceAttached(p[12]), .deviceDetached(p[13]),
    .busNonIdle(busNonIdle), .idPin(idPin), .vbusPin(vbusPin),
    .controllerReset(controllerReset), .transceiverEnable(transceiverEnable),
    .usbClockEnable(usbClockEnable), .resumeDetectEnable(),
    .hostMode(hostMode), .vbusPadEnable(vbusPadEnable),
    .bankKillRequest(bankKillRequest), .endpointIrq(endpointIrq),
    .hostIrq(hostIrq), .generalIrq(generalIrq));
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic ev(input int i);
    @(posedge core_clk);
    fire <= 1'b1; evIdx <= 4'(i);
    @(posedge core_clk);
    fire <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : ev
  task automatic close_out;
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    close_out();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(0, `OFS_GENERAL_CONTROL, 0); chk(rd, 32'h20);
    apb(1, `OFS_GENERAL_CONTROL, 32'h10);
    chk(vbusPadEnable, 1); chk(controllerReset, 1);
    apb(1, `OFS_GENERAL_CONTROL, 32'hFF);
    apb(0, `OFS_GENERAL_CONTROL, 0); chk(rd, 32'hF3);
    chk(hostMode, 1); chk(usbClockEnable, 0);
    apb(1, `OFS_GENERAL_CONTROL, 32'h90);
    chk(usbClockEnable, 1); chk(hostMode, 0);
    apb(0, 12'h020, 0); chk(err, 1);
    $display("test control done");
    apb(1, `OFS_GENERAL_CONTROL, 32'hD0);
    apb(1, `OFS_EP_ENABLES, 32'hFF);
    apb(0, `OFS_EP_ENABLES, 0); chk(rd, 32'hDF);
    apb(1, `OFS_HOST_ENABLES, 32'hFF);
    apb(0, `OFS_HOST_ENABLES, 0); chk(rd, 32'h7F);
    apb(1, `OFS_EP_FLAGS, 32'hFF);
    apb(0, `OFS_EP_FLAGS, 0); chk(rd, 0);
    for (int i = 0; i < 14; i++) begin
      if (i == 6) continue;
      case (i)
        0: e = 9'h010; 1: e = 9'h008; 2: e = 9'h004; 3, 4: e = 9'h002;
        5: e = 9'h001; 7, 8: e = 9'h120; 9: e = 9'h110; 10: e = 9'h108;
        11: e = 9'h104; 12: e = 9'h101; default: e = 9'h102;
      endcase
      a = e[8] ? `OFS_HOST_FLAGS : `OFS_EP_FLAGS;
      endpointIsIn <= (i == 5);
      ev(i);
      apb(0, a, 0); chk(rd, {24'h0, e[7:0]});
      chk(e[8] ? hostIrq : endpointIrq, 1);
      apb(1, a, 0); apb(0, a, 0); chk(rd, 0);
      chk(e[8] ? hostIrq : endpointIrq, 0);
    end
    $display("test events done");
    endpointIsIn <= 1'b1;
    apb(1, `OFS_EP_FLAGS, 32'h04); chk(bankKillRequest, 1);
    apb(1, `OFS_EP_FLAGS, 32'h00); chk(bankKillRequest, 1);
    ev(6); chk(bankKillRequest, 0);
    endpointIsIn <= 1'b0;
    apb(1, `OFS_EP_ENABLES, 32'hC0);
    overflowFlag <= 1'b1;
    @(posedge core_clk);
    chk(endpointIrq, 1);
    overflowFlag <= 1'b0;
    nakInFlag <= 1'b1;
    @(posedge core_clk);
    chk(endpointIrq, 1);
    apb(1, `OFS_EP_ENABLES, 32'h00); chk(endpointIrq, 0);
    nakInFlag <= 1'b0;
    busNonIdle <= 1'b1; repeat (8) @(posedge core_clk);
    apb(0, `OFS_HOST_FLAGS, 0); chk(rd, 32'h40);
    apb(1, `OFS_GENERAL_CONTROL, 32'hD2);
    idPin <= 1'b1; repeat (8) @(posedge core_clk);
    chk(generalIrq, 1);
    apb(1, `OFS_GENERAL_CONTROL, 32'hD0); chk(generalIrq, 0);
    $display("test kill and enables done");
    close_out();
  end
endmodule : test_usb_ctrl_irq_flags
